// >>> hdl/qspm_regs.vh
// Constants for the quadrature, SPI clock and test reset pin multiplexer
`ifndef QSPM_REGS_VH
`define QSPM_REGS_VH
`define QSPM_PORTC_FIRST_BIT    4
`define QSPM_PORTE_SCLK_BIT     4
`define QSPM_PUR_RST            4'hf
`define QSPM_PUR_E_RST          1'h1
`define QSPM_TSEL_RST           4'h0
`define QSPM_DIR_RST            1'h0
`define QSPM_IN_IDLE            1'h1
`define QSPM_PUDR_RST           1'h0
`define QSPM_SEL_PERIPH         1'h0
`define QSPM_SEL_GPIO           1'h1
`define QSPM_TA_SEL_TIMER       1'h1
`endif

// >>> hdl/qspm_pin_mux.v
// Pin multiplexer for quadrature decoder 0, SPI 0 clock and test reset pins
`timescale 1ns/1ps
`include "qspm_regs.vh"
module qspm_pin_mux (
    CLK,
    RST_B,
    TRST_B_IN,
    TRST_PULLUP_EN,
    TAP_RESET,
    SYSTEM_PULLUP_DISABLE,
    PORTC_PULLUP_ENABLE,
    PORTE_PULLUP_ENABLE,
    PORTC_FUNC_SEL,
    PORTC_TIMER_SEL,
    PORTE_FUNC_SEL,
    PORTC_DIR,
    PORTC_DATA_OUT,
    PORTC_DATA_IN,
    PORTE_DIR,
    PORTE_DATA_OUT,
    PORTE_DATA_IN,
    QUAD_PIN_IN,
    QUAD_PIN_OUT,
    QUAD_PIN_OE,
    QUAD_PIN_PULLUP,
    QUAD0_PHASE_A_IN,
    QUAD0_PHASE_B_IN,
    QUAD0_REV_MARKER_IN,
    QUAD0_REFERENCE_IN,
    TIMER_A_OUT,
    TIMER_A_OE,
    TIMER_A_IN,
    SPI0_MASTER,
    SPI0_CLK_OUT,
    SPI0_CLK_IN,
    SCLK_PIN_IN,
    SCLK_PIN_OUT,
    SCLK_PIN_OE,
    SCLK_PIN_PULLUP
);
    // Clock and device reset
    input  wire       CLK;
    input  wire       RST_B;

    // Test reset pin and its pull-up
    input  wire       TRST_B_IN;
    output wire       TRST_PULLUP_EN;
    output wire       TAP_RESET;
    input  wire       SYSTEM_PULLUP_DISABLE;

    // Pull-up enables of the port pins
    input  wire [3:0] PORTC_PULLUP_ENABLE;
    input  wire       PORTE_PULLUP_ENABLE;

    // Function selects of the port pins
    input  wire [3:0] PORTC_FUNC_SEL;
    input  wire [3:0] PORTC_TIMER_SEL;
    input  wire       PORTE_FUNC_SEL;

    // Port C GPIO direction and data
    input  wire [3:0] PORTC_DIR;
    input  wire [3:0] PORTC_DATA_OUT;
    output reg  [3:0] PORTC_DATA_IN;

    // Port E GPIO direction and data
    input  wire       PORTE_DIR;
    input  wire       PORTE_DATA_OUT;
    output reg        PORTE_DATA_IN;

    // Quadrature pin pads
    input  wire [3:0] QUAD_PIN_IN;
    output reg  [3:0] QUAD_PIN_OUT;
    output reg  [3:0] QUAD_PIN_OE;
    output reg  [3:0] QUAD_PIN_PULLUP;

    // Decoder 0 inputs
    output reg        QUAD0_PHASE_A_IN;
    output reg        QUAD0_PHASE_B_IN;
    output reg        QUAD0_REV_MARKER_IN;
    output reg        QUAD0_REFERENCE_IN;

    // Timer A channels
    input  wire [3:0] TIMER_A_OUT;
    input  wire [3:0] TIMER_A_OE;
    output reg  [3:0] TIMER_A_IN;

    // SPI 0 clock side of the serial block
    input  wire       SPI0_MASTER;
    input  wire       SPI0_CLK_OUT;
    output reg        SPI0_CLK_IN;

    // SPI 0 clock pin pad
    input  wire       SCLK_PIN_IN;
    output reg        SCLK_PIN_OUT;
    output reg        SCLK_PIN_OE;
    output reg        SCLK_PIN_PULLUP;

    // Registered copies of the configuration ports
    reg       pudr_r;
    reg [3:0] c_pur_r;
    reg       e_pur_r;
    reg [3:0] c_sel_r;
    reg [3:0] c_tsel_r;
    reg       e_sel_r;
    reg [3:0] c_dir_r;
    reg       e_dir_r;

    // Configuration is held at peripheral, input, pull-up while in reset
    always @(posedge CLK) begin
        if (!RST_B) begin
            pudr_r   <= `QSPM_PUDR_RST;
            c_pur_r  <= `QSPM_PUR_RST;
            e_pur_r  <= `QSPM_PUR_E_RST;
            c_sel_r  <= {4{`QSPM_SEL_PERIPH}};
            c_tsel_r <= `QSPM_TSEL_RST;
            e_sel_r  <= `QSPM_SEL_PERIPH;
            c_dir_r  <= {4{`QSPM_DIR_RST}};
            e_dir_r  <= `QSPM_DIR_RST;
        end else begin
            pudr_r   <= SYSTEM_PULLUP_DISABLE;
            c_pur_r  <= PORTC_PULLUP_ENABLE;
            e_pur_r  <= PORTE_PULLUP_ENABLE;
            c_sel_r  <= PORTC_FUNC_SEL;
            c_tsel_r <= PORTC_TIMER_SEL;
            e_sel_r  <= PORTE_FUNC_SEL;
            c_dir_r  <= PORTC_DIR;
            e_dir_r  <= PORTE_DIR;
        end
    end

    // Test reset is a pin-level reset, not gated by the device reset
    assign TAP_RESET      = ~TRST_B_IN;
    assign TRST_PULLUP_EN = ~pudr_r;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_quad
            always @* begin
                QUAD_PIN_PULLUP[i] = c_pur_r[i];
                if (c_sel_r[i] == `QSPM_SEL_GPIO) begin
                    QUAD_PIN_OE[i]  = c_dir_r[i];
                    QUAD_PIN_OUT[i] = PORTC_DATA_OUT[i];
                end else if (c_tsel_r[i] == `QSPM_TA_SEL_TIMER) begin
                    QUAD_PIN_OE[i]  = TIMER_A_OE[i];
                    QUAD_PIN_OUT[i] = TIMER_A_OUT[i];
                end else begin
                    QUAD_PIN_OE[i]  = 1'b0;
                    QUAD_PIN_OUT[i] = 1'b0;
                end
            end
            // Inputs seen by peripherals go idle-high when not routed
            always @(posedge CLK) begin
                if (!RST_B) begin
                    PORTC_DATA_IN[i] <= `QSPM_IN_IDLE;
                    TIMER_A_IN[i]    <= `QSPM_IN_IDLE;
                end else begin
                    PORTC_DATA_IN[i] <= QUAD_PIN_IN[i];
                    TIMER_A_IN[i]    <= (c_sel_r[i] != `QSPM_SEL_GPIO && c_tsel_r[i] == `QSPM_TA_SEL_TIMER)
                                        ? QUAD_PIN_IN[i] : 1'b1;
                end
            end
        end
    endgenerate

    // A pin reaches the decoder only when neither GPIO nor timer is selected
    wire [3:0] quad_route = (~c_sel_r) & (~c_tsel_r);

    // Decoder inputs read idle-high unless their pin is routed to the decoder
    always @(posedge CLK) begin
        if (!RST_B) begin
            QUAD0_PHASE_A_IN    <= `QSPM_IN_IDLE;
            QUAD0_PHASE_B_IN    <= `QSPM_IN_IDLE;
            QUAD0_REV_MARKER_IN <= `QSPM_IN_IDLE;
            QUAD0_REFERENCE_IN  <= `QSPM_IN_IDLE;
        end else begin
            QUAD0_PHASE_A_IN    <= quad_route[0] ? QUAD_PIN_IN[0] : 1'b1;
            QUAD0_PHASE_B_IN    <= quad_route[1] ? QUAD_PIN_IN[1] : 1'b1;
            QUAD0_REV_MARKER_IN <= quad_route[2] ? QUAD_PIN_IN[2] : 1'b1;
            QUAD0_REFERENCE_IN  <= quad_route[3] ? QUAD_PIN_IN[3] : 1'b1;
        end
    end

    // The SPI block sees the pin clock only as a slave, so a master never hears itself
    wire spi_slave_route = (e_sel_r == `QSPM_SEL_PERIPH) && !SPI0_MASTER;

    // Port E bit reads the pin level whatever function is selected
    always @(posedge CLK) begin
        if (!RST_B) begin
            PORTE_DATA_IN <= `QSPM_IN_IDLE;
            SPI0_CLK_IN   <= `QSPM_IN_IDLE;
        end else begin
            PORTE_DATA_IN <= SCLK_PIN_IN;
            SPI0_CLK_IN   <= spi_slave_route ? SCLK_PIN_IN : 1'b1;
        end
    end

    // Master drive is cut at once by reset so the pin falls back to its pull-up
    always @* begin
        SCLK_PIN_PULLUP = e_pur_r;
        if (e_sel_r == `QSPM_SEL_GPIO) begin
            SCLK_PIN_OE  = e_dir_r;
            SCLK_PIN_OUT = PORTE_DATA_OUT;
        end else begin
            SCLK_PIN_OE  = SPI0_MASTER & RST_B;
            SCLK_PIN_OUT = SPI0_CLK_OUT;
        end
    end

endmodule // qspm_pin_mux

// >>> testbench/qspm_pin_model.sv
// Encoder, SPI peer and pull-up model for the multiplexed pins
`timescale 1ns/1ps
module qspm_pin_model #(parameter W = 4) (
    input  wire  [W-1:0] clk,
    input  wire  [W-1:0] ext_en,
    input  wire  [W-1:0] ext_val,
    input  wire  [W-1:0] dut_out,
    input  wire  [W-1:0] dut_oe,
    input  wire  [W-1:0] dut_pu,
    output logic [W-1:0] pin
);
    logic [W-1:0] last = '0;
    always @(posedge clk[0]) last <= pin;
    // A pin nobody drives or pulls floats to the inverse of its last level
    assign pin = (dut_oe & dut_out) | (~dut_oe & ext_en & ext_val) | (~dut_oe & ~ext_en & (dut_pu | ~last));
endmodule // qspm_pin_model

// >>> testbench/qspm_monitor.sv
// Port checker for the quadrature, SPI clock and test reset pin multiplexer
`timescale 1ns/1ps
module qspm_monitor (
    input wire       CLK, RST_B, TRST_B_IN, TRST_PULLUP_EN, TAP_RESET, SYSTEM_PULLUP_DISABLE,
    input wire       PORTE_PULLUP_ENABLE, PORTE_FUNC_SEL, SPI0_MASTER, SPI0_CLK_IN, QUAD0_PHASE_A_IN,
    input wire       SCLK_PIN_IN, SCLK_PIN_OE, SCLK_PIN_PULLUP,
    input wire [3:0] PORTC_PULLUP_ENABLE, PORTC_FUNC_SEL, PORTC_TIMER_SEL, PORTC_DIR,
    input wire [3:0] QUAD_PIN_IN, QUAD_PIN_OE, QUAD_PIN_PULLUP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    property p_tap; TAP_RESET == !TRST_B_IN; endproperty
    a_tap: assert property (p_tap) else $error("tap reset");
    property p_trst; $past(RST_B) |-> TRST_PULLUP_EN == !$past(SYSTEM_PULLUP_DISABLE); endproperty
    a_trst: assert property (p_trst) else $error("trst pull-up");
    property p_pu; $past(RST_B) |-> {QUAD_PIN_PULLUP, SCLK_PIN_PULLUP} ==
        $past({PORTC_PULLUP_ENABLE, PORTE_PULLUP_ENABLE}); endproperty
    a_pu: assert property (p_pu) else $error("pull-up");
    property p_rst; disable iff (1'b0) (!RST_B)[*2] |->
        !QUAD_PIN_OE && !SCLK_PIN_OE && &QUAD_PIN_PULLUP && SCLK_PIN_PULLUP && TRST_PULLUP_EN; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_oe; $past(RST_B) |-> (QUAD_PIN_OE & $past(PORTC_FUNC_SEL)) ==
        $past(PORTC_FUNC_SEL & PORTC_DIR); endproperty
    a_oe: assert property (p_oe) else $error("gpio dir");
    property p_sck; $past(RST_B) && !$past(PORTE_FUNC_SEL) && $stable(SPI0_MASTER) |-> SCLK_PIN_OE == SPI0_MASTER;
    endproperty
    a_sck: assert property (p_sck) else $error("sclk dir");
    property p_pha; (RST_B && !PORTC_FUNC_SEL[0] && !PORTC_TIMER_SEL[0])[*3] |->
        QUAD0_PHASE_A_IN == $past(QUAD_PIN_IN[0]); endproperty
    a_pha: assert property (p_pha) else $error("phase a");
    property p_sin; (RST_B && !PORTE_FUNC_SEL && !SPI0_MASTER)[*3] |-> SPI0_CLK_IN == $past(SCLK_PIN_IN); endproperty
    a_sin: assert property (p_sin) else $error("sclk in");
    cover property (PORTC_FUNC_SEL[0] && PORTC_DIR[0]);
    cover property (SPI0_MASTER && !PORTE_FUNC_SEL);
    cover property (!TRST_B_IN && RST_B);
endmodule // qspm_monitor
bind qspm_pin_mux qspm_monitor i_qspm_monitor (.*);

// >>> testbench/tb_top.sv
// Random and corner tests of the pin multiplexer
`timescale 1ns/1ps
module tb_top;
    logic CLK = 0, RST_B = 0, TRST_B_IN = 0, SYSTEM_PULLUP_DISABLE = 0, PORTE_PULLUP_ENABLE = 1, PORTE_FUNC_SEL = 0;
    logic PORTE_DIR = 0, PORTE_DATA_OUT = 0, SPI0_MASTER = 0, SPI0_CLK_OUT = 0, s_en = 0, s_val = 0, sp;
    logic [3:0] PORTC_PULLUP_ENABLE = '1, PORTC_FUNC_SEL = 0, PORTC_TIMER_SEL = 0, PORTC_DIR = 0, PORTC_DATA_OUT = 0;
    logic [3:0] TIMER_A_OUT = 0, TIMER_A_OE = 0, q_en = 0, q_val = 0, qp;
    wire  [3:0] QUAD_PIN_IN, QUAD_PIN_OUT, QUAD_PIN_OE, QUAD_PIN_PULLUP, PORTC_DATA_IN, TIMER_A_IN;
    wire        TRST_PULLUP_EN, TAP_RESET, PORTE_DATA_IN, QUAD0_PHASE_A_IN, QUAD0_PHASE_B_IN, QUAD0_REV_MARKER_IN;
    wire        QUAD0_REFERENCE_IN, SPI0_CLK_IN, SCLK_PIN_IN, SCLK_PIN_OUT, SCLK_PIN_OE, SCLK_PIN_PULLUP;
    int         miscompares = 0, n_tests = 0;
    qspm_pin_mux i_qspm_pin_mux (.*);
    qspm_pin_model i_qm (.clk({4{CLK}}), .ext_en(q_en), .ext_val(q_val), .dut_out(QUAD_PIN_OUT),
        .dut_oe(QUAD_PIN_OE), .dut_pu(QUAD_PIN_PULLUP), .pin(QUAD_PIN_IN));
    qspm_pin_model #(.W(1)) i_sm (.clk(CLK), .ext_en(s_en), .ext_val(s_val), .dut_out(SCLK_PIN_OUT),
        .dut_oe(SCLK_PIN_OE), .dut_pu(SCLK_PIN_PULLUP), .pin(SCLK_PIN_IN));
    always #5 CLK = ~CLK;
    task chk(input string n, input logic [3:0] e, input logic [3:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    function logic [3:0] exp_oe(input logic [3:0] s, input logic [3:0] d, input logic [3:0] t, input logic [3:0] o);
        return (s & d) | (~s & t & o);
    endfunction
    task final_report;
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task rst_chk(input logic tb);
        chk("oe", 4'h0, QUAD_PIN_OE | SCLK_PIN_OE);
        chk("pu", 4'hf, QUAD_PIN_PULLUP & {4{SCLK_PIN_PULLUP}});
        chk("tap", !tb, TAP_RESET);
        chk("dec", 4'hf, {QUAD0_REFERENCE_IN, QUAD0_REV_MARKER_IN, QUAD0_PHASE_B_IN, QUAD0_PHASE_A_IN});
        chk("rst_in", 4'hf, PORTC_DATA_IN & TIMER_A_IN & {4{PORTE_DATA_IN & SPI0_CLK_IN}});
    endtask
    initial begin
        void'($urandom(32'h2e9f));
        repeat (16) @(negedge CLK);
        rst_chk(0);
        RST_B = 1;
        repeat (400) begin
            {PORTC_FUNC_SEL, PORTC_TIMER_SEL, PORTC_DIR, PORTC_DATA_OUT, TIMER_A_OE, TIMER_A_OUT, PORTC_PULLUP_ENABLE,
                q_en} = $urandom;
            {q_val, PORTE_FUNC_SEL, PORTE_DIR, PORTE_DATA_OUT, SPI0_MASTER, SPI0_CLK_OUT, s_en, s_val,
                PORTE_PULLUP_ENABLE, SYSTEM_PULLUP_DISABLE, TRST_B_IN} = 14'($urandom);
            repeat (2) @(negedge CLK);
            qp = QUAD_PIN_IN;
            sp = SCLK_PIN_IN;
            @(negedge CLK);
            chk("oe", exp_oe(PORTC_FUNC_SEL, PORTC_DIR, PORTC_TIMER_SEL, TIMER_A_OE), QUAD_PIN_OE);
            chk("pu", PORTC_PULLUP_ENABLE, QUAD_PIN_PULLUP);
            chk("dec", qp | PORTC_FUNC_SEL | PORTC_TIMER_SEL,
                {QUAD0_REFERENCE_IN, QUAD0_REV_MARKER_IN, QUAD0_PHASE_B_IN, QUAD0_PHASE_A_IN});
            chk("sclk_oe", exp_oe(PORTE_FUNC_SEL, PORTE_DIR, 1, SPI0_MASTER), SCLK_PIN_OE);
            chk("trst_pu", !SYSTEM_PULLUP_DISABLE, TRST_PULLUP_EN);
            chk("tap", !TRST_B_IN, TAP_RESET);
            chk("pin_out", exp_oe(PORTC_FUNC_SEL, PORTC_DATA_OUT, PORTC_TIMER_SEL, TIMER_A_OUT), QUAD_PIN_OUT);
            chk("portc_in", qp, PORTC_DATA_IN);
            chk("timer_in", qp | PORTC_FUNC_SEL | ~PORTC_TIMER_SEL, TIMER_A_IN);
            chk("sclk_out", exp_oe(PORTE_FUNC_SEL, PORTE_DATA_OUT, 1, SPI0_CLK_OUT), SCLK_PIN_OUT);
            chk("sclk_pu", PORTE_PULLUP_ENABLE, SCLK_PIN_PULLUP);
            chk("porte_in", sp, PORTE_DATA_IN);
            chk("spi_in", sp | PORTE_FUNC_SEL | SPI0_MASTER, SPI0_CLK_IN);
        end
        RST_B = 0;
        TRST_B_IN = 1;
        repeat (3) @(negedge CLK);
        rst_chk(1);
        final_report;
    end
endmodule // tb_top
